// file: src/wat_pkg.sv
// constants shared by the watch/interval timer block
// assumes a 32-bit AXI4-Lite slave port with 28-bit byte addresses
package wat_pkg;

  // ****************************************************************
  // bus geometry and register map
  // ****************************************************************
  localparam int          ADDR_W      = 28;
  localparam int          DATA_W      = 32;
  localparam int          WORD_LSB    = 2;
  localparam logic [27:0] MODE_ADDR   = 28'hFFFF680;
  localparam logic [27:0] STAT_ADDR   = 28'hFFFF684;
  localparam logic [27:0] MASK_ADDR   = 28'hFFFF688;
  localparam logic [27:0] STATE_ADDR  = 28'hFFFF68C;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************************************
  // mode register fields
  // ****************************************************************
  localparam int         MODE_W       = 8;
  localparam logic [7:0] MODE_RST     = 8'h00;
  localparam int         EN_BIT       = 0;
  localparam int         RUN_BIT      = 1;
  localparam int         WPER_LO      = 2;
  localparam int         WPER_HI      = 3;
  localparam int         ISEL_LO      = 4;
  localparam int         ISEL_HI      = 6;
  localparam int         SRC_BIT      = 7;

  // ****************************************************************
  // counter geometry
  // ****************************************************************
  localparam int PRESC_W    = 11;
  localparam int WCNT_W     = 5;
  localparam int ISEL_W     = 3;
  localparam int TAP_BASE   = 4;
  localparam int TAP_N      = 8;
  localparam int COARSE_TAP = 9;
  localparam int HALF_W     = 4;

  // ****************************************************************
  // interrupt status / mask layout, state readback layout
  // ****************************************************************
  localparam int         IRQ_W      = 2;
  localparam int         IRQ_WATCH  = 0;
  localparam int         IRQ_INTV   = 1;
  localparam logic [1:0] IRQ_RST    = 2'h0;
  localparam int         STATE_CNT  = 0;
  localparam int         STATE_PRE  = 16;

endpackage : wat_pkg

// file: src/wat_sync_edge.sv
// two-flop synchroniser with rising-edge detector
// assumes the sampled clock is far slower than core_clk
module wat_sync_edge (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // pin side
  input  wire logic asyncIn,
  // core side
  output logic      rise
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else if (ce) begin
      meta_r <= asyncIn;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign rise = ce & sync_r & ~last_r;

endmodule : wat_sync_edge

// file: src/wat_timer.sv
// watch timer with companion interval timer, AXI4-Lite register port
// assumes both watch clock sources are slow pins asynchronous to core_clk

module wat_timer
  import wat_pkg::*;
(
  // clock, reset, freeze
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // watch clock sources
  input  wire logic              subClkIn,
  input  wire logic              companionClkIn,
  // axi write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  // axi write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // axi write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // axi read address
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  // axi read data
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // interrupts
  output logic                   watchIrq,
  output logic                   intervalIrq,
  output logic                   irq
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  // asserts at once, releases on the clock so no flop sees a late edge
  logic rstPipe_r;
  logic rstSync_r;
  wire  sysRst_n = rstSync_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstPipe_r <= 1'b1;
      rstSync_r <= rstPipe_r;
    end
  end

  // ****************************************************************
  // state declarations
  // ****************************************************************
  logic [MODE_W-1:0]  mode_r;
  logic [MODE_W-1:0]  mode_nxt;
  logic [PRESC_W-1:0] presc_r;
  logic [PRESC_W-1:0] presc_nxt;
  logic [WCNT_W-1:0]  wcnt_r;
  logic [WCNT_W-1:0]  wcnt_nxt;
  logic [IRQ_W-1:0]   status_r;
  logic [IRQ_W-1:0]   status_nxt;
  logic [IRQ_W-1:0]   mask_r;
  logic [IRQ_W-1:0]   mask_nxt;
  logic               watchIrq_r;
  logic               intervalIrq_r;
  logic               irq_r;

  // ****************************************************************
  // watch clock sources
  // ****************************************************************
  // each pin costs about two core cycles before its tick shows up
  logic subRise;
  logic compRise;

  wat_sync_edge u_subSync (
    .core_clk (core_clk),
    .rst_n    (sysRst_n),
    .ce       (ce),
    .asyncIn  (subClkIn),
    .rise     (subRise)
  );

  wat_sync_edge u_compSync (
    .core_clk (core_clk),
    .rst_n    (sysRst_n),
    .ce       (ce),
    .asyncIn  (companionClkIn),
    .rise     (compRise)
  );

  // ****************************************************************
  // mode decode
  // ****************************************************************
  wire              opEn     = mode_r[EN_BIT];
  wire              cntRun   = mode_r[RUN_BIT];
  wire              perHalf  = mode_r[WPER_LO];
  wire              perFine  = mode_r[WPER_HI];
  wire [ISEL_W-1:0] isel     = mode_r[ISEL_HI:ISEL_LO];
  wire              srcComp  = mode_r[SRC_BIT];
  wire              watchTick = srcComp ? compRise : subRise;
  wire              counting = opEn & cntRun;

  // ****************************************************************
  // prescaler taps
  // ****************************************************************
  // tap k rolls over every 2^(TAP_BASE+k) watch clocks
  logic [TAP_N-1:0] tapRoll;

  genvar gk;
  generate
    for (gk = 0; gk < TAP_N; gk++) begin : g_tap
      assign tapRoll[gk] = &presc_r[TAP_BASE+gk-1:0];
    end
  endgenerate

  wire coarseRoll = tapRoll[COARSE_TAP-TAP_BASE];

  // prescaler ignores the run bit so the interval path is never disturbed
  assign presc_nxt = !opEn ? '0
                   : watchTick ? presc_r + 1'b1
                   : presc_r;

  wire intervalEv = opEn & watchTick & tapRoll[isel];

  // ****************************************************************
  // watch counter
  // ****************************************************************
  // coarse periods count fw/2^9, fine ones count fw itself
  wire cntTick  = perFine ? watchTick : (watchTick & coarseRoll);
  wire halfWrap = &wcnt_r[HALF_W-1:0];
  wire fullWrap = &wcnt_r;
  wire wrapHit  = perHalf ? halfWrap : fullWrap;

  assign wcnt_nxt = !counting ? '0
                  : cntTick ? wcnt_r + 1'b1
                  : wcnt_r;

  // in coarse periods the counter starts mid-prescaler, so the first event lands early
  wire watchEv = counting & cntTick & wrapHit;

  // ****************************************************************
  // axi write channel
  // ****************************************************************
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              awHeld_r;
  logic              wHeld_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0]        wstrb_r;

  // readies sit high in reset; masters must keep valids low until release
  wire awTake = s_axi_awvalid & awready_r;
  wire wTake  = s_axi_wvalid & wready_r;
  wire bDone  = bvalid_r & s_axi_bready;
  wire doWr   = awHeld_r & wHeld_r & ~bvalid_r;

  wire [ADDR_W-1:0] wWord = {waddr_r[ADDR_W-1:WORD_LSB], 2'b00};
  wire wHitMode  = (wWord == MODE_ADDR);
  wire wHitStat  = (wWord == STAT_ADDR);
  wire wHitMask  = (wWord == MASK_ADDR);
  wire wHitState = (wWord == STATE_ADDR);
  wire wMapped   = wHitMode | wHitStat | wHitMask | wHitState;
  wire lane0     = doWr & wstrb_r[0];

  always_ff @(posedge core_clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      awHeld_r  <= 1'b0;
      wHeld_r   <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      waddr_r   <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else if (ce) begin
      if (awTake) begin
        awready_r <= 1'b0;
        awHeld_r  <= 1'b1;
        waddr_r   <= s_axi_awaddr;
      end
      if (wTake) begin
        wready_r <= 1'b0;
        wHeld_r  <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (doWr) begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wMapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (bDone) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  // bit-level updates arrive as read-modify-write of the low byte
  assign mode_nxt = (lane0 & wHitMode) ? wdata_r[MODE_W-1:0]
                  : mode_r;
  assign mask_nxt = (lane0 & wHitMask) ? wdata_r[IRQ_W-1:0] : mask_r;

  // write-one-to-clear; a fresh event in the same cycle survives
  wire [IRQ_W-1:0] statClr = (lane0 & wHitStat) ? wdata_r[IRQ_W-1:0]
                                                : IRQ_RST;
  wire [IRQ_W-1:0] statSet;
  assign statSet[IRQ_WATCH] = watchEv;
  assign statSet[IRQ_INTV]  = intervalEv;
  assign status_nxt = (status_r & ~statClr) | statSet;

  // ****************************************************************
  // axi read channel
  // ****************************************************************
  logic              arready_r;
  logic              rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0]        rresp_r;

  wire arTake = s_axi_arvalid & arready_r;
  wire rDone  = rvalid_r & s_axi_rready;

  wire [ADDR_W-1:0] rWord = {s_axi_araddr[ADDR_W-1:WORD_LSB], 2'b00};
  wire rHitMode  = (rWord == MODE_ADDR);
  wire rHitStat  = (rWord == STAT_ADDR);
  wire rHitMask  = (rWord == MASK_ADDR);
  wire rHitState = (rWord == STATE_ADDR);
  wire rMapped   = rHitMode | rHitStat | rHitMask | rHitState;

  // block state readback: counter low, prescaler high
  logic [DATA_W-1:0] stateWord;
  always_comb begin
    stateWord = '0;
    stateWord[STATE_CNT +: WCNT_W]  = wcnt_r;
    stateWord[STATE_PRE +: PRESC_W] = presc_r;
  end

  wire [DATA_W-1:0] rdMux =
      rHitMode  ? {{(DATA_W-MODE_W){1'b0}}, mode_r}
    : rHitStat  ? {{(DATA_W-IRQ_W){1'b0}}, status_r}
    : rHitMask  ? {{(DATA_W-IRQ_W){1'b0}}, mask_r}
    : rHitState ? stateWord
    : '0;

  always_ff @(posedge core_clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else if (ce) begin
      if (arTake) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rdMux;
        rresp_r   <= rMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rDone) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // timer and interrupt state
  // ****************************************************************
  always_ff @(posedge core_clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      mode_r        <= MODE_RST;
      presc_r       <= '0;
      wcnt_r        <= '0;
      status_r      <= IRQ_RST;
      mask_r        <= IRQ_RST;
      watchIrq_r    <= 1'b0;
      intervalIrq_r <= 1'b0;
      irq_r         <= 1'b0;
    end else if (ce) begin
      mode_r        <= mode_nxt;
      presc_r       <= presc_nxt;
      wcnt_r        <= wcnt_nxt;
      status_r      <= status_nxt;
      mask_r        <= mask_nxt;
      watchIrq_r    <= watchEv;
      intervalIrq_r <= intervalEv;
      irq_r         <= |(status_nxt & mask_nxt);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign watchIrq      = watchIrq_r;
  assign intervalIrq   = intervalIrq_r;
  assign irq           = irq_r;

endmodule : wat_timer

// file: sim/wat_timer_checker.sv
// port checker for the watch/interval timer
// bound to every wat_timer; sees only its ports
module wat_timer_checker
  import wat_pkg::*;
(
  // clock, reset, watch clock pins
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              subClkIn,
  input wire logic              companionClkIn,
  // bus handshakes
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  // interrupts
  input wire logic              watchIrq,
  input wire logic              intervalIrq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // cycles since the last rising edge on either clock pin
  // ****************************************************************
  logic [1:0] pinPrev_r;
  logic [3:0] sinceEdge_r;
  logic [3:0] sinceEdge_nxt;
  logic       pinRise;

  assign pinRise = |({subClkIn, companionClkIn} & ~pinPrev_r);
  // saturate so a long quiet spell never wraps back to a small value
  assign sinceEdge_nxt = pinRise ? 4'h0 :
                         (sinceEdge_r == 4'hF) ? 4'hF : sinceEdge_r + 4'h1;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinPrev_r   <= 2'h0;
      sinceEdge_r <= 4'hF;
    end else begin
      pinPrev_r   <= {subClkIn, companionClkIn};
      sinceEdge_r <= sinceEdge_nxt;
    end
  end

  watch_pulse_a: assert property (watchIrq |=> !watchIrq)
    else $error("watch pulse longer than one cycle");
  intv_pulse_a: assert property (intervalIrq |=> !intervalIrq)
    else $error("interval pulse longer than one cycle");
  watch_cause_a: assert property (watchIrq |-> sinceEdge_r <= 4'h8)
    else $error("watch pulse without a watch clock edge");
  intv_cause_a: assert property (intervalIrq |-> sinceEdge_r <= 4'h8)
    else $error("interval pulse without a watch clock edge");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  wr_block_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write accepted early");
endmodule : wat_timer_checker

bind wat_timer wat_timer_checker u_chk (
  .core_clk, .rst_n, .subClkIn, .companionClkIn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .watchIrq, .intervalIrq
);

// file: sim/wat_timer_tb_top.sv
// self-checking bench for the watch/interval timer
// drives both watch clock pins slowly; wstrb is held fixed
module wat_timer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import wat_pkg::*;

  logic core_clk, rst_n, ce, subClkIn, companionClkIn;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, watchIrq, intervalIrq, irq;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  int                err_total, n_tests, wCnt, iCnt;

  wat_timer u_dut (
    .core_clk, .rst_n, .ce, .subClkIn, .companionClkIn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .watchIrq, .intervalIrq, .irq
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (watchIrq === 1'b1) wCnt++;
    if (intervalIrq === 1'b1) iCnt++;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic finish_test();
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic to();
    err_total++;
    finish_test();
  endtask : to

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [27:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    int k;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 50) to();
    chk(s_axi_bresp, er);
  endtask : wr

  task automatic rd(input logic [27:0] a);
    int k;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (k == 50) to();
  endtask : rd

  task automatic m(input logic [7:0] v);
    wr(MODE_ADDR, {24'h0, v}, RESP_OKAY);
  endtask : m

  // one steady watch clock; the unselected pin stays still
  task automatic tk(input int n, input logic onComp);
    repeat (n) begin
      if (onComp) companionClkIn <= 1'b1;
      else subClkIn <= 1'b1;
      repeat (4) @(posedge core_clk);
      companionClkIn <= 1'b0;
      subClkIn       <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask : tk

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      rd(i == 0 ? MODE_ADDR : i == 1 ? STAT_ADDR :
         i == 2 ? MASK_ADDR : STATE_ADDR);
      chk(d, 32'h0);
      chk(r, RESP_OKAY);
    end
    wr(MODE_ADDR, 32'h1234_56A4, RESP_OKAY);
    rd(MODE_ADDR);
    chk(d, 32'hA4);
    wr(28'hFFFF690, 32'hFF, RESP_SLVERR);
    rd(28'hFFFF690);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    m(8'h00);
  endtask : t_regs

  task automatic t_interval();
    int per;
    for (int n = 0; n < 8; n++) begin
      per = (n < 6) ? 2 : 1;
      m(8'h00);
      m({n[0], n[2:0], 4'h0});
      m({n[0], n[2:0], 4'h1});
      iCnt = 0;
      tk(per << (4 + n), n[0]);
      chk(iCnt, per);
    end
    m(8'h00);
    m(8'h81);
    iCnt = 0;
    tk(32, 1'b0);
    chk(iCnt, 0);
  endtask : t_interval

  task automatic t_watch();
    int k;
    for (int s = 2; s < 4; s++) begin
      m(8'h00);
      m(8'(s << 2));
      m(8'(s << 2) | 8'h03);
      wCnt = 0;
      for (k = 0; k < 100 && wCnt == 0; k++) tk(1, 1'b0);
      if (wCnt == 0) to();
      wCnt = 0;
      tk((s == 3 ? 16 : 32) * 3, 1'b0);
      chk(wCnt, 3);
      rd(STAT_ADDR);
      chk(d, 32'h3);
      wr(STAT_ADDR, 32'h3, RESP_OKAY);
    end
  endtask : t_watch

  task automatic t_coarse();
    for (int s = 0; s < 2; s++) begin
      m(8'h00);
      m(8'(s << 2));
      m(8'(s << 2) | 8'h03);
      wCnt = 0;
      tk(600, 1'b0);
      rd(STATE_ADDR);
      chk(d[4:0], 1);
      chk(d[26:16], 600);
      chk(wCnt, 0);
      m(8'(s << 2) | 8'h01);
      rd(STATE_ADDR);
      chk(d, 32'd600 << 16);
      iCnt = 0;
      tk(32, 1'b0);
      chk(iCnt, 2);
      m(8'(s << 2));
      rd(STATE_ADDR);
      chk(d, 32'h0);
    end
  endtask : t_coarse

  task automatic t_irq();
    wr(STAT_ADDR, 32'h3, RESP_OKAY);
    m(8'h01);
    tk(16, 1'b0);
    m(8'h00);
    rd(STAT_ADDR);
    chk(d, 32'h2);
    chk(irq, 1'b0);
    wr(MASK_ADDR, 32'h2, RESP_OKAY);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b1);
    wr(STAT_ADDR, 32'h2, RESP_OKAY);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0);
    rd(MASK_ADDR);
    chk(d, 32'h2);
  endtask : t_irq

  // ticks arriving while ce is low must be lost, not counted later
  task automatic t_freeze();
    m(8'h01);
    ce <= 1'b0;
    tk(4, 1'b0);
    ce <= 1'b1;
    rd(STATE_ADDR);
    chk(d, 32'h0);
    m(8'h00);
  endtask : t_freeze

  initial begin
    {rst_n, subClkIn, companionClkIn, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'b101;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {err_total, n_tests, wCnt, iCnt} = '0;
    ce          = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_regs();
    t_interval();
    t_watch();
    t_coarse();
    t_irq();
    t_freeze();
    finish_test();
  end
endmodule : wat_timer_tb_top
